// ---- verilog/flbp_pkg.sv ----
// constants, types and helpers shared by the flash protection block
// assumes a single 20 MHz system clock domain
package flbp_pkg;

localparam int unsigned FLASH_KB = 96;
localparam int unsigned WORD_BYTES = 4;
localparam int unsigned ERASE_BLK_BYTES = 1024;
localparam int unsigned UNIT_BYTES = 2048;
localparam int unsigned WORDS = FLASH_KB * 1024 / WORD_BYTES;
localparam int unsigned BLK_WORDS = ERASE_BLK_BYTES / WORD_BYTES;
localparam int unsigned UNIT_WORDS = UNIT_BYTES / WORD_BYTES;
localparam int unsigned UNITS = WORDS / UNIT_WORDS;
localparam int unsigned AW = 15;
localparam int unsigned DW = 32;
localparam int unsigned BLK_SHIFT = 8;
localparam int unsigned UNIT_SHIFT = 9;
localparam int unsigned BLK_IDX_W = AW - BLK_SHIFT;
localparam int unsigned UNIT_IDX_W = AW - UNIT_SHIFT;
localparam logic [BLK_SHIFT-1:0] ERASE_LAST = 8'hFF;
localparam logic [DW-1:0] ERASED_WORD = 32'hFFFFFFFF;
localparam logic [DW-1:0] DENIED_WORD = 32'h00000000;
localparam logic [1:0] RST_SYNC = 2'h0;

typedef enum logic [1:0] {
    FLBP_OPEN = 2'b00,
    FLBP_READ_ONLY = 2'b01,
    FLBP_EXEC_ONLY = 2'b10
} flbp_mode_e;

typedef enum logic [2:0] {
    FLBP_FETCH = 3'b000,
    FLBP_DATA_READ = 3'b001,
    FLBP_DEBUG_READ = 3'b010,
    FLBP_PROGRAM = 3'b011,
    FLBP_ERASE = 3'b100
} flbp_kind_e;

typedef struct packed {
    flbp_kind_e kind;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
} flbp_req_s;

typedef struct packed {
    logic [DW-1:0] data;
    logic denied;
} flbp_rsp_s;

function automatic logic [UNIT_IDX_W-1:0] unit_of(input logic [AW-1:0] a);
    unit_of = a[AW-1:UNIT_SHIFT];
endfunction

function automatic logic [BLK_IDX_W-1:0] blk_of(input logic [AW-1:0] a);
    blk_of = a[AW-1:BLK_SHIFT];
endfunction

endpackage

// ---- verilog/flbp_prot_check.sv ----
// protection decision for one request against the per-unit modes
// assumes modes are held by the caller, two bits per unit
`timescale 1ns/1ps
module flbp_prot_check #(
    parameter int unsigned UNITS = 48
) (
    input wire logic [2*UNITS-1:0] modes,
    input wire flbp_pkg::flbp_kind_e kind,
    input wire logic [flbp_pkg::AW-1:0] addr,
    output logic allow,
    output flbp_pkg::flbp_mode_e mode
);

logic [flbp_pkg::UNIT_IDX_W-1:0] unit;
logic in_range;

always_comb begin
    unit = flbp_pkg::unit_of(addr);
    in_range = 32'(unit) < UNITS;
    mode = in_range ? flbp_pkg::flbp_mode_e'(modes[2*unit +: 2])
                    : flbp_pkg::FLBP_OPEN;
    allow = in_range;
    case (kind)
        flbp_pkg::FLBP_PROGRAM, flbp_pkg::FLBP_ERASE: begin
            // either protected mode locks contents
            if (mode != flbp_pkg::FLBP_OPEN) begin
                allow = 1'b0;
            end
        end
        flbp_pkg::FLBP_DATA_READ, flbp_pkg::FLBP_DEBUG_READ: begin
            if (mode == flbp_pkg::FLBP_EXEC_ONLY) begin
                allow = 1'b0;
            end
        end
        default: begin
        end
    endcase
end

endmodule

// ---- verilog/flbp_flash_block_protection.sv ----
// flash array with erase sequencer and per-unit protection
// assumes inputs synchronous to clk; settings come from system control
`timescale 1ns/1ps
module flbp_flash_block_protection #(
    parameter int unsigned UNITS = flbp_pkg::UNITS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic req_valid,
    output logic req_ready,
    input wire flbp_pkg::flbp_req_s req,
    output logic rsp_valid_ff,
    output flbp_pkg::flbp_rsp_s rsp_ff,
    input wire logic mode_wr,
    input wire logic [flbp_pkg::UNIT_IDX_W-1:0] mode_unit,
    input wire flbp_pkg::flbp_mode_e mode_val,
    output logic [2*UNITS-1:0] modes_ff,
    output logic blocked_ff,
    input wire logic blocked_clr,
    output logic erase_busy_ff
);

// refuse a unit count that does not tile the array exactly
if (UNITS * flbp_pkg::UNIT_WORDS != flbp_pkg::WORDS) begin : g_bad_units
    $error("unit count must tile the array");
end

////////////////////////////////////////////////////////////////////////
// reset release

logic [1:0] rst_sync_ff;
logic rst_n;

always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        rst_sync_ff <= flbp_pkg::RST_SYNC;
    end else begin
        rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
end

assign rst_n = rst_sync_ff[1];

////////////////////////////////////////////////////////////////////////
// request decode

logic take;
logic allow;
logic is_read;
logic is_prog;
logic is_erase;
flbp_pkg::flbp_mode_e req_mode;

flbp_prot_check #(
    .UNITS(UNITS)
) u_check (
    .modes(modes_ff),
    .kind(req.kind),
    .addr(req.addr),
    .allow(allow),
    .mode(req_mode)
);

// erase walks one word a cycle, so nothing is taken meanwhile
assign req_ready = !erase_busy_ff;
assign take = req_valid && req_ready;
assign is_prog = req.kind == flbp_pkg::FLBP_PROGRAM;
assign is_erase = req.kind == flbp_pkg::FLBP_ERASE;
assign is_read = !is_prog && !is_erase;

////////////////////////////////////////////////////////////////////////
// protection modes, one field per unit

always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        modes_ff <= '0;
    end else if (mode_wr && 32'(mode_unit) < UNITS) begin
        modes_ff[2*mode_unit +: 2] <= mode_val;
    end
end

////////////////////////////////////////////////////////////////////////
// erase sequencer

logic [flbp_pkg::BLK_IDX_W-1:0] erase_blk_ff;
logic [flbp_pkg::BLK_SHIFT-1:0] erase_ptr_ff;

always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        erase_busy_ff <= 1'b0;
        erase_blk_ff <= '0;
        erase_ptr_ff <= '0;
    end else if (erase_busy_ff) begin
        erase_ptr_ff <= erase_ptr_ff + 1'b1;
        if (erase_ptr_ff == flbp_pkg::ERASE_LAST) begin
            erase_busy_ff <= 1'b0;
        end
    end else if (take && is_erase && allow) begin
        erase_busy_ff <= 1'b1;
        erase_blk_ff <= flbp_pkg::blk_of(req.addr);
        erase_ptr_ff <= '0;
    end
end

////////////////////////////////////////////////////////////////////////
// array and its single write port

logic [flbp_pkg::DW-1:0] mem [flbp_pkg::WORDS];
logic mem_we;
logic [flbp_pkg::AW-1:0] mem_wa;
logic [flbp_pkg::DW-1:0] mem_wd;

always_comb begin
    mem_we = 1'b0;
    mem_wa = req.addr;
    mem_wd = req.wdata;
    if (erase_busy_ff) begin
        mem_we = 1'b1;
        mem_wa = {erase_blk_ff, erase_ptr_ff};
        mem_wd = flbp_pkg::ERASED_WORD;
    end else if (take && is_prog && allow) begin
        mem_we = 1'b1;
        // programming only clears bits, as in real flash
        mem_wd = mem[req.addr] & req.wdata;
    end
end

// no reset on the array: contents survive a system reset
always_ff @(posedge clk) begin
    if (mem_we) begin
        mem[mem_wa] <= mem_wd;
    end
end

////////////////////////////////////////////////////////////////////////
// read answer, one cycle after the request is taken

always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        rsp_valid_ff <= 1'b0;
        rsp_ff <= '0;
    end else begin
        rsp_valid_ff <= take && is_read;
        if (take && is_read) begin
            rsp_ff.denied <= !allow;
            rsp_ff.data <= allow ? mem[req.addr] : flbp_pkg::DENIED_WORD;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// refusal flag; a new refusal beats a clear in the same cycle

always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        blocked_ff <= 1'b0;
    end else if (take && !allow) begin
        blocked_ff <= 1'b1;
    end else if (blocked_clr) begin
        blocked_ff <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////
// checks

logic [flbp_pkg::UNIT_IDX_W-1:0] wr_unit;
flbp_pkg::flbp_mode_e wr_mode;

assign wr_unit = flbp_pkg::unit_of(mem_wa);
assign wr_mode = flbp_pkg::flbp_mode_e'(modes_ff[2*wr_unit +: 2]);

sequence s_erase_start;
    take && is_erase && allow;
endsequence

sequence s_erase_walk;
    erase_busy_ff [*8];
endsequence

a_erase_whole_block: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_erase_start |=> s_erase_walk ##248 erase_busy_ff ##1 !erase_busy_ff)
    else $error("erase did not cover exactly one block");

// walk starts at word zero, steps by one and stays in its block
a_erase_writes_one: assert property (
    @(posedge clk) disable iff (!rst_n)
    erase_busy_ff |-> mem_we && mem_wd == flbp_pkg::ERASED_WORD
        && (!$past(erase_busy_ff) ? erase_ptr_ff == 8'h00
            : erase_ptr_ff == $past(erase_ptr_ff) + 8'h01
                && $stable(erase_blk_ff)))
    else $error("erase wrote a non-erased word");

a_unit_mode_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    mode_wr && 32'(mode_unit) < UNITS |=>
        modes_ff[2*$past(mode_unit) +: 2] == $past(mode_val))
    else $error("unit mode not stored");

a_ro_no_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    mem_we && !erase_busy_ff |-> wr_mode != flbp_pkg::FLBP_READ_ONLY)
    else $error("read-only unit modified");

a_ro_no_erase: assert property (
    @(posedge clk) disable iff (!rst_n)
    take && is_erase && req_mode == flbp_pkg::FLBP_READ_ONLY
    |=> !erase_busy_ff)
    else $error("read-only unit erased");

a_xo_no_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    take && (is_prog || is_erase) && req_mode == flbp_pkg::FLBP_EXEC_ONLY
    |-> !mem_we ##1 !erase_busy_ff)
    else $error("execute-only unit modified");

a_xo_data_denied: assert property (
    @(posedge clk) disable iff (!rst_n)
    take && (req.kind == flbp_pkg::FLBP_DATA_READ
        || req.kind == flbp_pkg::FLBP_DEBUG_READ)
        && req_mode == flbp_pkg::FLBP_EXEC_ONLY
    |=> rsp_valid_ff && rsp_ff.denied
        && rsp_ff.data == flbp_pkg::DENIED_WORD)
    else $error("execute-only data leaked");

a_read_one_cycle: assert property (
    @(posedge clk) disable iff (!rst_n)
    take && is_read && allow
    |=> rsp_valid_ff && !rsp_ff.denied
        ##1 !rsp_valid_ff || $past(take && is_read))
    else $error("read not answered in one cycle");

a_block_flag: assert property (
    @(posedge clk) disable iff (!rst_n)
    take && !allow |-> !mem_we ##1 blocked_ff)
    else $error("refusal not flagged or array written");

endmodule

// ---- testbench/flbp_cpu_model.sv ----
// processor fetch, data and debug side facing the flash protection block
// assumes caller enters xfer just after a falling edge of clk
`timescale 1ns/1ps
module flbp_cpu_model (
    input wire logic clk,
    input wire logic req_ready,
    input wire logic rsp_valid_ff,
    input wire flbp_pkg::flbp_rsp_s rsp_ff,
    output logic req_valid,
    output flbp_pkg::flbp_req_s req
);
initial begin
    req_valid = 1'b0;
    req = '0;
end
////////////////////////////////////////////////////////////////////////
// request held until taken; fields scrambled once released
task automatic xfer(input flbp_pkg::flbp_kind_e k, input logic [14:0] a,
    input logic [31:0] d, output logic ok, output logic vld,
    output flbp_pkg::flbp_rsp_s r);
    int n;
    n = 0;
    // one idle edge keeps back-to-back calls out of one time step
    @(negedge clk);
    req_valid = 1'b1;
    req = '{kind: k, addr: a, wdata: d};
    // ready only moves on rising edges, so the falling edge view is safe
    while (req_ready !== 1'b1 && n < 400) begin
        @(negedge clk);
        n++;
    end
    ok = req_ready;
    @(posedge clk);
    @(negedge clk);
    vld = rsp_valid_ff;
    r = rsp_ff;
    req_valid = 1'b0;
    req = ~req;
endtask
endmodule

// ---- testbench/flash_block_protection_tb.sv ----
// self-checking bench for the flash protection block
// assumes the cpu model drives requests; bench drives modes and clear
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
module flash_block_protection_tb;
localparam flbp_pkg::flbp_kind_e FE = flbp_pkg::FLBP_FETCH;
localparam flbp_pkg::flbp_kind_e RD = flbp_pkg::FLBP_DATA_READ;
localparam flbp_pkg::flbp_kind_e DB = flbp_pkg::FLBP_DEBUG_READ;
localparam flbp_pkg::flbp_kind_e PG = flbp_pkg::FLBP_PROGRAM;
localparam flbp_pkg::flbp_kind_e ER = flbp_pkg::FLBP_ERASE;
localparam logic [31:0] ONES = flbp_pkg::ERASED_WORD;
logic clk = 1'b0;
logic resetn = 1'b0;
logic req_valid, req_ready, rsp_valid_ff, mode_wr = 1'b0;
logic blocked_ff, blocked_clr = 1'b0, erase_busy_ff, ok, vld;
logic [5:0] mode_unit = '0;
logic [2*flbp_pkg::UNITS-1:0] modes_ff;
flbp_pkg::flbp_mode_e mode_val = flbp_pkg::FLBP_OPEN;
flbp_pkg::flbp_req_s req;
flbp_pkg::flbp_rsp_s rsp_ff, r;
int n_fail = 0;
int n_compared = 0;
always #25 clk = ~clk;
flbp_flash_block_protection dut_u (.clk(clk), .resetn(resetn),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid_ff(rsp_valid_ff), .rsp_ff(rsp_ff), .mode_wr(mode_wr),
    .mode_unit(mode_unit), .mode_val(mode_val), .modes_ff(modes_ff),
    .blocked_ff(blocked_ff), .blocked_clr(blocked_clr),
    .erase_busy_ff(erase_busy_ff));
flbp_cpu_model cpu_u (.clk(clk), .req_ready(req_ready),
    .rsp_valid_ff(rsp_valid_ff), .rsp_ff(rsp_ff),
    .req_valid(req_valid), .req(req));
////////////////////////////////////////////////////////////////////////
task automatic finish_test;
    if (n_fail == 0 && n_compared > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask
task automatic go(flbp_pkg::flbp_kind_e k, logic [14:0] a, logic [31:0] d);
    cpu_u.xfer(k, a, d, ok, vld, r);
    if (ok !== 1'b1) begin
        n_fail++;
        finish_test();
    end
endtask
task automatic rd(flbp_pkg::flbp_kind_e k, logic [14:0] a, logic [31:0] d,
    logic den);
    go(k, a, '0);
    `CHK(vld, 1'b1)
    `CHK(r, {d, den})
endtask
task automatic erase(logic [14:0] a);
    int n;
    n = 0;
    go(ER, a, '0);
    `CHK(req_ready, 1'b0)
    // busy must stand for the whole block walk
    while (erase_busy_ff === 1'b1 && n < 300) begin
        @(negedge clk);
        n++;
    end
    `CHK(n, 256)
    if (n >= 300) begin
        finish_test();
    end
endtask
task automatic set_mode(logic [5:0] u, flbp_pkg::flbp_mode_e m);
    mode_wr = 1'b1;
    mode_unit = u;
    mode_val = m;
    @(negedge clk);
    mode_wr = 1'b0;
    `CHK(modes_ff[2*u +: 2], m)
endtask
task automatic clear_flag;
    blocked_clr = 1'b1;
    @(negedge clk);
    blocked_clr = 1'b0;
    `CHK(blocked_ff, 1'b0)
endtask
////////////////////////////////////////////////////////////////////////
task automatic t_reset;
    `CHK({req_ready, rsp_valid_ff, blocked_ff, erase_busy_ff},
        4'h8)
    `CHK(modes_ff, '0)
endtask
task automatic t_erase_program;
    erase(15'h0200);
    go(PG, 15'h0200, 32'h0F0F0F0F);
    rd(RD, 15'h0200, 32'h0F0F0F0F, 1'b0);
    go(PG, 15'h0200, 32'h3C3C3C3C);
    rd(RD, 15'h0200, 32'h0C0C0C0C, 1'b0);
    erase(15'h0000);
    rd(RD, 15'h0000, ONES, 1'b0);
    rd(DB, 15'h00FF, ONES, 1'b0);
    rd(RD, 15'h0200, 32'h0C0C0C0C, 1'b0);
    // second half of unit zero gets a known non-erased word
    erase(15'h0100);
    go(PG, 15'h01FF, 32'h00000000);
    rd(DB, 15'h01FF, 32'h00000000, 1'b0);
    `CHK(blocked_ff, 1'b0)
endtask
task automatic t_read_only;
    set_mode(6'h00, flbp_pkg::FLBP_READ_ONLY);
    go(PG, 15'h0000, 32'h00000000);
    `CHK(blocked_ff, 1'b1)
    rd(RD, 15'h0000, ONES, 1'b0);
    clear_flag();
    go(ER, 15'h01FF, '0);
    `CHK(erase_busy_ff, 1'b0)
    `CHK(blocked_ff, 1'b1)
    rd(DB, 15'h01FF, 32'h00000000, 1'b0);
    clear_flag();
    rd(RD, 15'h6000, 32'h00000000, 1'b1);
    `CHK(blocked_ff, 1'b1)
    clear_flag();
endtask
task automatic t_exec_only;
    set_mode(6'h00, flbp_pkg::FLBP_EXEC_ONLY);
    rd(FE, 15'h0000, ONES, 1'b0);
    `CHK(blocked_ff, 1'b0)
    rd(RD, 15'h0000, 32'h00000000, 1'b1);
    `CHK(blocked_ff, 1'b1)
    // clear held across a refusal: the refusal must win
    blocked_clr = 1'b1;
    rd(DB, 15'h00FF, 32'h00000000, 1'b1);
    `CHK(blocked_ff, 1'b1)
    @(negedge clk);
    blocked_clr = 1'b0;
    `CHK(blocked_ff, 1'b0)
    go(PG, 15'h0000, 32'h00000000);
    `CHK(blocked_ff, 1'b1)
    go(ER, 15'h0000, '0);
    `CHK(erase_busy_ff, 1'b0)
    rd(FE, 15'h0000, ONES, 1'b0);
    clear_flag();
    go(PG, 15'h0200, 32'h00000000);
    rd(RD, 15'h0200, 32'h00000000, 1'b0);
    `CHK(blocked_ff, 1'b0)
endtask
////////////////////////////////////////////////////////////////////////
initial begin
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    t_erase_program();
    t_read_only();
    t_exec_only();
    finish_test();
end
endmodule
